// >>> hdl/fer_pkg.sv
// Package for the fieldbus error-reporting block: bit positions, codes, types
package fer_pkg;
	// Monitoring latch bit positions
	localparam int MON_GENERAL = 0;
	localparam int MON_HW_LIMIT = 1;
	localparam int MON_OUT_OF_RANGE = 2;
	localparam int MON_QUICK_STOP = 3;
	localparam int MON_OP_MODE = 4;
	localparam int MON_COMM_IF = 5;
	localparam int MON_FIELDBUS = 6;
	localparam int MON_FOLLOWING = 8;
	localparam int MON_STO_ZERO = 10;
	localparam int MON_STO_DIFF = 11;
	localparam int MON_DC_LOW_A = 13;
	localparam int MON_DC_LOW_B = 14;
	localparam int MON_MAINS_PHASE = 15;
	localparam int MON_ENCODER_IF = 16;
	localparam int MON_MOTOR_TEMP = 17;
	localparam int MON_STAGE_TEMP = 18;
	localparam int MON_MEM_CARD = 20;
	localparam int MON_BUS_MODULE = 21;
	localparam int MON_ENC_MODULE = 22;
	localparam int MON_SAFETY_MODULE = 23;
	localparam int MON_MOTOR_CONN = 26;
	localparam int MON_OVERCURRENT = 27;
	localparam int MON_REF_FREQ = 28;
	localparam int MON_NVM = 29;
	localparam int MON_STARTUP = 30;
	localparam int MON_SYSTEM = 31;
	// Implemented positions; all others are reserved and read zero
	localparam logic [31:0] MON_USED_MASK = 32'hfcf7ed7f;
	localparam logic [31:0] MON_RESET = 32'h00000000;

	// Error register bit positions
	localparam int ERR_GENERIC = 0;
	localparam int ERR_COMM = 4;
	localparam int ERR_PROFILE = 5;
	localparam int ERR_VENDOR = 7;
	localparam logic [7:0] ERR_RESET = 8'h00;
	localparam logic [15:0] CODE_RESET = 16'h0000;

	// Abort message layout: cause code in bytes 4..7, little endian
	localparam int ABORT_CODE_BYTE = 4;
	localparam logic [7:0] ABORT_CMD = 8'h80;

	// Abort cause codes
	localparam logic [31:0] AB_TOGGLE = 32'h05030000;
	localparam logic [31:0] AB_TIMEOUT = 32'h05040000;
	localparam logic [31:0] AB_BAD_CS = 32'h05040001;
	localparam logic [31:0] AB_NO_MEMORY = 32'h05040005;
	localparam logic [31:0] AB_NO_ACCESS = 32'h06010000;
	localparam logic [31:0] AB_WRITE_ONLY = 32'h06010001;
	localparam logic [31:0] AB_READ_ONLY = 32'h06010002;
	localparam logic [31:0] AB_NO_OBJECT = 32'h06020000;
	localparam logic [31:0] AB_NOT_MAPPABLE = 32'h06040041;
	localparam logic [31:0] AB_MAP_TOO_LONG = 32'h06040042;
	localparam logic [31:0] AB_INCOMPATIBLE = 32'h06040043;
	localparam logic [31:0] AB_INTERNAL_INC = 32'h06040047;
	localparam logic [31:0] AB_HW_ERROR = 32'h06060000;
	localparam logic [31:0] AB_LEN_MISMATCH = 32'h06070010;
	localparam logic [31:0] AB_TOO_LONG = 32'h06070012;
	localparam logic [31:0] AB_TOO_SHORT = 32'h06070013;
	localparam logic [31:0] AB_NO_SUBINDEX = 32'h06090011;
	localparam logic [31:0] AB_RANGE_LARGE = 32'h06090030;
	localparam logic [31:0] AB_ABOVE_MAX = 32'h06090031;
	localparam logic [31:0] AB_BELOW_MIN = 32'h06090032;
	localparam logic [31:0] AB_UPPER_LOWER = 32'h06090036;
	localparam logic [31:0] AB_GENERAL = 32'h08000000;
	localparam logic [31:0] AB_NOT_STORED = 32'h08000020;
	localparam logic [31:0] AB_LOCAL_CTRL = 32'h08000021;
	localparam logic [31:0] AB_DEV_STATE = 32'h08000022;
	localparam logic [31:0] AB_NO_DICT = 32'h08000023;
	localparam logic [31:0] AB_NO_DATA = 32'h08000024;

	// Transfer failure causes reported by the service-data engine
	typedef enum logic [4:0] {
		FC_TOGGLE, FC_TIMEOUT, FC_BAD_CS, FC_NO_MEMORY, FC_NO_ACCESS,
		FC_WRITE_ONLY, FC_READ_ONLY, FC_NO_OBJECT, FC_NOT_MAPPABLE, FC_MAP_TOO_LONG,
		FC_INCOMPATIBLE, FC_INTERNAL_INC, FC_HW_ERROR, FC_LEN_MISMATCH, FC_TOO_LONG,
		FC_TOO_SHORT, FC_NO_SUBINDEX, FC_RANGE_LARGE, FC_ABOVE_MAX, FC_BELOW_MIN,
		FC_UPPER_LOWER, FC_GENERAL, FC_NOT_STORED, FC_LOCAL_CTRL, FC_DEV_STATE,
		FC_NO_DICT, FC_NO_DATA
	} fer_fail_t;

	// Failed transfer request from the service-data engine
	typedef struct packed {
		fer_fail_t cause;
		logic is_write;
		logic [15:0] index;
		logic [7:0] subindex;
		logic [15:0] vendor_detail;
	} fer_sdo_fail_t;

	// Abort message handed to the frame transmitter
	typedef struct packed {
		logic [7:0][7:0] data;
	} fer_abort_msg_t;

	// Emergency report to the frame transmitter
	typedef struct packed {
		logic [15:0] error_code;
		logic [7:0] error_register;
	} fer_emcy_t;
endpackage : fer_pkg

// >>> hdl/fer_abort_coder.sv
// Combinational translator from failure cause to abort code
`timescale 1ns/1ns
module fer_abort_coder
	import fer_pkg::*;
(
	// Cause
	input wire fer_fail_t cause_i,
	input wire logic is_write_i,
	// Code
	output logic [31:0] code_o
);
	always_comb begin
		case (cause_i)
			FC_TOGGLE: code_o = AB_TOGGLE; // [RULE12]
			FC_TIMEOUT: code_o = AB_TIMEOUT; // [RULE12]
			FC_BAD_CS: code_o = AB_BAD_CS; // [RULE12]
			FC_NO_MEMORY: code_o = AB_NO_MEMORY; // [RULE22]
			FC_HW_ERROR: code_o = AB_HW_ERROR; // [RULE22]
			FC_NO_ACCESS: code_o = AB_NO_ACCESS; // [RULE13]
			FC_WRITE_ONLY: code_o = AB_WRITE_ONLY; // [RULE13]
			FC_READ_ONLY: code_o = AB_READ_ONLY; // [RULE13]
			FC_NO_OBJECT: code_o = AB_NO_OBJECT; // [RULE14]
			FC_NO_SUBINDEX: code_o = AB_NO_SUBINDEX; // [RULE14]
			FC_NOT_MAPPABLE: code_o = AB_NOT_MAPPABLE; // [RULE15]
			FC_MAP_TOO_LONG: code_o = AB_MAP_TOO_LONG; // [RULE15]
			FC_INCOMPATIBLE: code_o = AB_INCOMPATIBLE; // [RULE23]
			FC_INTERNAL_INC: code_o = AB_INTERNAL_INC; // [RULE23]
			FC_LEN_MISMATCH: code_o = AB_LEN_MISMATCH; // [RULE16]
			FC_TOO_LONG: code_o = AB_TOO_LONG; // [RULE16]
			FC_TOO_SHORT: code_o = AB_TOO_SHORT; // [RULE16]
			FC_ABOVE_MAX: code_o = AB_ABOVE_MAX; // [RULE17]
			FC_BELOW_MIN: code_o = AB_BELOW_MIN; // [RULE17]
			FC_UPPER_LOWER: code_o = AB_UPPER_LOWER; // [RULE17]
			// Range code is meaningful only on writes; a read falls back to general
			FC_RANGE_LARGE: code_o = is_write_i ? AB_RANGE_LARGE : AB_GENERAL; // [RULE18]
			FC_NOT_STORED: code_o = AB_NOT_STORED; // [RULE20]
			FC_LOCAL_CTRL: code_o = AB_LOCAL_CTRL; // [RULE20]
			FC_DEV_STATE: code_o = AB_DEV_STATE; // [RULE20]
			FC_NO_DICT: code_o = AB_NO_DICT; // [RULE21]
			FC_NO_DATA: code_o = AB_NO_DATA; // [RULE21]
			FC_GENERAL: code_o = AB_GENERAL;
			default: code_o = AB_GENERAL;
		endcase
	end
endmodule : fer_abort_coder

// >>> hdl/fer_error_report.sv
// Top of the fieldbus error-reporting block
`timescale 1ns/1ns
////////////////////////////////////////////////////////////////////////////////
// Operation
// RULE1 - 32-bit read-only latch, one means activated
// RULE2 - Bits 0-6: general, limits, range, stop, mode, interfaces
// RULE3 - Bits 8,10,11,13-15: following, safe torque, voltage
// RULE4 - Bits 16-18, 20-23: encoder, temperatures, modules
// RULE5 - Bits 26-31: motor, frequency, memory, startup, system
// RULE6 - Errors reported to master as emergency messages
// RULE7 - Failed transfer answered with abort message
// RULE8 - Error register bit 0 set immediately
// RULE9 - Bits 4,5,7 communication, profile, vendor
// RULE10 - 16-bit code of last motion interruption
// RULE11 - Abort cause code in bytes 4 to 7
// RULE12 - Toggle, timeout, bad command specifier codes
// RULE13 - Access impossible, write-only, read-only codes
// RULE14 - Missing object, unsupported subindex codes
// RULE15 - Not mappable, mapping too long codes
// RULE16 - Length mismatch, too long, too short codes
// RULE17 - Above maximum, below minimum, bounds reversed codes
// RULE18 - Range too large only on writes
// RULE19 - General abort exposes 16-bit vendor detail
// RULE20 - Not stored, local control, device state codes
// RULE21 - No dictionary, data unavailable codes
// RULE22 - No memory, hardware error codes
// RULE23 - Incompatible parameters, internal incompatibility codes
// RULE24 - Latched bits held until fault reset, reserved zero
module fer_error_report
	import fer_pkg::*;
(
	// Clock and reset
	input wire logic clk_i,
	input wire logic rstn_i,
	input wire logic ce_i,
	// Monitoring sources, from outside the clock domain
	input wire logic [31:0] monitor_raw_i,
	input wire logic fault_reset_i,
	// Error classification from the drive
	input wire logic comm_error_i,
	input wire logic profile_error_i,
	input wire logic vendor_error_i,
	input wire logic stop_event_i,
	input wire logic [15:0] stop_code_i,
	// Failed service-data transfer
	input wire logic sdo_fail_valid_i,
	input wire fer_sdo_fail_t sdo_fail_i,
	// Registers
	output logic [31:0] latched_monitor_signals_o,
	output logic [7:0] bitcoded_error_register_o,
	output logic [15:0] last_stop_code_o,
	output logic [15:0] vendor_abort_detail_o,
	// Abort message out
	output logic abort_valid_o,
	output fer_abort_msg_t abort_msg_o,
	// Emergency message out
	output logic emcy_valid_o,
	output fer_emcy_t emcy_o
);
	////////////////////////////////////////////////////////////////////////////
	// Input synchronisers
	logic [31:0] mon_meta;
	logic [31:0] mon_sync;
	logic fr_meta;
	logic fr_sync;
	logic fr_prev;
	logic fault_reset_pulse;

	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			mon_meta <= MON_RESET;
			mon_sync <= MON_RESET;
			fr_meta <= 1'b0;
			fr_sync <= 1'b0;
			fr_prev <= 1'b0;
		end else if (ce_i) begin
			mon_meta <= monitor_raw_i;
			mon_sync <= mon_meta;
			fr_meta <= fault_reset_i;
			fr_sync <= fr_meta;
			fr_prev <= fr_sync;
		end
	end

	assign fault_reset_pulse = fr_sync && !fr_prev;

	////////////////////////////////////////////////////////////////////////////
	// Monitoring latch
	logic [31:0] mon_latch;
	logic [31:0] mon_new;
	logic [31:0] next_mon_latch;

	// Only documented positions can ever latch
	assign mon_new = mon_sync & MON_USED_MASK; // [RULE24] [RULE2] [RULE3] [RULE4] [RULE5]
	// A condition still active during a fault reset survives it
	assign next_mon_latch = fault_reset_pulse ? mon_new : (mon_latch | mon_new); // [RULE24]

	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			mon_latch <= MON_RESET;
		end else if (ce_i) begin
			mon_latch <= next_mon_latch; // [RULE1]
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Error register
	logic [7:0] err_reg;
	logic [7:0] next_err_reg;
	logic any_error;
	logic comm_now;
	logic vendor_now;

	assign comm_now = comm_error_i || sdo_fail_valid_i;
	assign vendor_now = vendor_error_i
		|| (sdo_fail_valid_i && sdo_fail_i.cause == FC_GENERAL);
	assign any_error = comm_now || profile_error_i || vendor_now || stop_event_i
		|| (|mon_new);

	always_comb begin
		next_err_reg = err_reg;
		if (fault_reset_pulse) begin
			next_err_reg = ERR_RESET;
		end
		// New errors win over a fault reset in the same cycle
		if (any_error) begin
			next_err_reg[ERR_GENERIC] = 1'b1; // [RULE8]
		end
		if (comm_now) begin
			next_err_reg[ERR_COMM] = 1'b1; // [RULE9]
		end
		if (profile_error_i || stop_event_i) begin
			next_err_reg[ERR_PROFILE] = 1'b1; // [RULE9]
		end
		if (vendor_now) begin
			next_err_reg[ERR_VENDOR] = 1'b1; // [RULE9]
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			err_reg <= ERR_RESET;
		end else if (ce_i) begin
			err_reg <= next_err_reg;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Last interruption code
	logic [15:0] stop_code;

	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			stop_code <= CODE_RESET;
		end else if (ce_i) begin
			if (stop_event_i) begin
				stop_code <= stop_code_i; // [RULE10]
			end else if (fault_reset_pulse) begin
				stop_code <= CODE_RESET;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Abort message generation
	logic [31:0] abort_code;
	logic [15:0] vendor_detail;
	logic abort_valid;
	fer_abort_msg_t abort_msg;
	fer_abort_msg_t next_abort_msg;

	fer_abort_coder i_fer_abort_coder (
		.cause_i(sdo_fail_i.cause),
		.is_write_i(sdo_fail_i.is_write),
		.code_o(abort_code)
	);

	always_comb begin
		next_abort_msg.data = '0;
		next_abort_msg.data[0] = ABORT_CMD;
		next_abort_msg.data[1] = sdo_fail_i.index[7:0];
		next_abort_msg.data[2] = sdo_fail_i.index[15:8];
		next_abort_msg.data[3] = sdo_fail_i.subindex;
		// Cause code rides little endian in bytes 4..7
		next_abort_msg.data[ABORT_CODE_BYTE] = abort_code[7:0]; // [RULE11]
		next_abort_msg.data[ABORT_CODE_BYTE + 1] = abort_code[15:8]; // [RULE11]
		next_abort_msg.data[ABORT_CODE_BYTE + 2] = abort_code[23:16]; // [RULE11]
		next_abort_msg.data[ABORT_CODE_BYTE + 3] = abort_code[31:24]; // [RULE11]
	end

	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			abort_valid <= 1'b0;
			abort_msg <= '0;
		end else if (ce_i) begin
			// Replaces the normal answer for this transfer
			abort_valid <= sdo_fail_valid_i; // [RULE7]
			if (sdo_fail_valid_i) begin
				abort_msg <= next_abort_msg; // [RULE7]
			end
		end
	end

	// Detail is only refreshed by a general abort; others leave it standing
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			vendor_detail <= CODE_RESET;
		end else if (ce_i) begin
			if (sdo_fail_valid_i && abort_code == AB_GENERAL) begin
				vendor_detail <= sdo_fail_i.vendor_detail; // [RULE19]
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Emergency reporting
	logic emcy_valid;
	fer_emcy_t emcy;
	logic [31:0] mon_rise;

	// Only fresh events raise a message, not conditions that persist
	assign mon_rise = mon_new & ~mon_latch;

	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			emcy_valid <= 1'b0;
			emcy <= '0;
		end else if (ce_i) begin
			emcy_valid <= stop_event_i || comm_error_i || profile_error_i
				|| vendor_error_i || (|mon_rise); // [RULE6]
			emcy.error_register <= next_err_reg; // [RULE6]
			emcy.error_code <= stop_event_i ? stop_code_i : stop_code; // [RULE6]
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Outputs
	assign latched_monitor_signals_o = mon_latch;
	assign bitcoded_error_register_o = err_reg;
	assign last_stop_code_o = stop_code;
	assign vendor_abort_detail_o = vendor_detail;
	assign abort_valid_o = abort_valid;
	assign abort_msg_o = abort_msg;
	assign emcy_valid_o = emcy_valid;
	assign emcy_o = emcy;
endmodule : fer_error_report

// >>> testbench/fer_error_report_asserts.sv
// Concurrent checks on the error-reporting top module
`timescale 1ns/1ns
module fer_error_report_asserts
	import fer_pkg::*;
(
	// Inputs
	input wire logic clk_i,
	input wire logic rstn_i,
	input wire logic ce_i,
	input wire logic fault_reset_i,
	input wire logic stop_event_i,
	input wire logic [15:0] stop_code_i,
	input wire logic sdo_fail_valid_i,
	// Outputs
	input wire logic [31:0] latched_monitor_signals_o,
	input wire logic [7:0] bitcoded_error_register_o,
	input wire logic [15:0] last_stop_code_o,
	input wire logic abort_valid_o,
	input wire fer_abort_msg_t abort_msg_o,
	input wire logic emcy_valid_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rstn_i);
	////////////////////////////////////////
	property p_reserved_zero;
		(latched_monitor_signals_o & ~MON_USED_MASK) == 32'h0;
	endproperty
	a_reserved_zero: assert property (p_reserved_zero) else $error("reserved latch bit");
	property p_err_reserved;
		bitcoded_error_register_o[3:1] == 3'h0 && !bitcoded_error_register_o[6];
	endproperty
	a_err_reserved: assert property (p_err_reserved) else $error("reserved error bit");
	property p_generic_bit;
		sdo_fail_valid_i && ce_i |=> bitcoded_error_register_o[0] && bitcoded_error_register_o[4];
	endproperty
	a_generic_bit: assert property (p_generic_bit) else $error("error bits not set");
	property p_abort_answer;
		sdo_fail_valid_i && ce_i |=> abort_valid_o;
	endproperty
	a_abort_answer: assert property (p_abort_answer) else $error("abort missing");
	property p_abort_cause;
		abort_valid_o && $past(ce_i) |-> $past(sdo_fail_valid_i);
	endproperty
	a_abort_cause: assert property (p_abort_cause) else $error("abort without failure");
	property p_stop_code;
		stop_event_i && ce_i |=> last_stop_code_o == $past(stop_code_i) && bitcoded_error_register_o[5];
	endproperty
	a_stop_code: assert property (p_stop_code) else $error("stop code not taken");
	property p_cmd_byte;
		abort_valid_o |-> abort_msg_o.data[0] == ABORT_CMD;
	endproperty
	a_cmd_byte: assert property (p_cmd_byte) else $error("abort command byte");
	property p_latch_hold;
		($past(latched_monitor_signals_o) & ~latched_monitor_signals_o) != 32'h0 |-> $past(fault_reset_i, 2);
	endproperty
	a_latch_hold: assert property (p_latch_hold) else $error("latch cleared early");
	property p_emcy_latch;
		(latched_monitor_signals_o & ~$past(latched_monitor_signals_o)) != 32'h0
			|-> emcy_valid_o && bitcoded_error_register_o[0];
	endproperty
	a_emcy_latch: assert property (p_emcy_latch) else $error("no emergency on latch");
	c_abort: cover property (abort_valid_o);
	c_emcy: cover property (emcy_valid_o);
	c_clear: cover property ($fell(latched_monitor_signals_o[0]));
endmodule : fer_error_report_asserts

bind fer_error_report fer_error_report_asserts i_fer_error_report_asserts (
	.clk_i(clk_i), .rstn_i(rstn_i), .ce_i(ce_i), .fault_reset_i(fault_reset_i),
	.stop_event_i(stop_event_i), .stop_code_i(stop_code_i), .sdo_fail_valid_i(sdo_fail_valid_i),
	.latched_monitor_signals_o(latched_monitor_signals_o),
	.bitcoded_error_register_o(bitcoded_error_register_o), .last_stop_code_o(last_stop_code_o),
	.abort_valid_o(abort_valid_o), .abort_msg_o(abort_msg_o), .emcy_valid_o(emcy_valid_o));

// >>> testbench/fer_master_model.sv
// Behavioural fieldbus master that receives abort messages
`timescale 1ns/1ns
module fer_master_model
	import fer_pkg::*;
(
	// Clock
	input wire logic clk_i,
	// From the node
	input wire logic abort_valid_i,
	input wire fer_abort_msg_t abort_msg_i,
	input wire logic [15:0] detail_i,
	// Received
	output logic rx_o,
	output logic [63:0] rx_msg_o,
	output logic [15:0] rx_detail_o
);
	// Detail is read with the abort, before a later abort can replace it
	always @(posedge clk_i) begin
		rx_o <= abort_valid_i;
		if (abort_valid_i === 1'b1) begin
			rx_msg_o <= abort_msg_i;
			rx_detail_o <= detail_i;
		end
	end
endmodule : fer_master_model

// >>> testbench/test_fer_error_report.sv
// Self-checking bench for the fieldbus error-reporting block
`timescale 1ns/1ns
`define CHK(g, x) begin checks++; if ((g) !== (x)) begin errors++; \
	$display("ERROR t=%0t got %h exp %h", $time, (g), (x)); end end
module test_fer_error_report import fer_pkg::*;;
	logic clk_i = 1'b0, rstn_i = 1'b0, ce_i = 1'b1, fault_reset_i = 1'b0;
	logic comm_error_i = 1'b0, profile_error_i = 1'b0, vendor_error_i = 1'b0;
	logic stop_event_i = 1'b0, sdo_fail_valid_i = 1'b0, abort_valid_o, emcy_valid_o, rx_o;
	logic [15:0] stop_code_i = 16'h0, last_stop_code_o, vendor_abort_detail_o, rx_detail, sc;
	logic [31:0] monitor_raw_i = 32'h0, latched_monitor_signals_o, r, acc, codes [27];
	logic [7:0] bitcoded_error_register_o;
	logic [63:0] rx_msg;
	logic [80:0] e, exp_q [$];
	fer_sdo_fail_t sdo_fail_i = '0;
	fer_abort_msg_t abort_msg_o;
	fer_emcy_t emcy_o;
	int errors = 0, checks = 0, seed = 32'h78c0;
	////////////////////////////////////////
	fer_error_report i_fer_error_report (.clk_i(clk_i), .rstn_i(rstn_i), .ce_i(ce_i),
		.monitor_raw_i(monitor_raw_i), .fault_reset_i(fault_reset_i), .comm_error_i(comm_error_i),
		.profile_error_i(profile_error_i), .vendor_error_i(vendor_error_i),
		.stop_event_i(stop_event_i), .stop_code_i(stop_code_i), .sdo_fail_valid_i(sdo_fail_valid_i),
		.sdo_fail_i(sdo_fail_i), .latched_monitor_signals_o(latched_monitor_signals_o),
		.bitcoded_error_register_o(bitcoded_error_register_o), .last_stop_code_o(last_stop_code_o),
		.vendor_abort_detail_o(vendor_abort_detail_o), .abort_valid_o(abort_valid_o),
		.abort_msg_o(abort_msg_o), .emcy_valid_o(emcy_valid_o), .emcy_o(emcy_o));
	fer_master_model i_fer_master_model (.clk_i(clk_i), .abort_valid_i(abort_valid_o),
		.abort_msg_i(abort_msg_o), .detail_i(vendor_abort_detail_o), .rx_o(rx_o),
		.rx_msg_o(rx_msg), .rx_detail_o(rx_detail));
	always #10 clk_i = ~clk_i;
	task automatic end_of_test;
		if (errors == 0 && checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : end_of_test
	// One mask drives all event strobes, so back-to-back calls assign each once per edge
	task automatic pulse(input logic [3:0] m);
		{comm_error_i, profile_error_i, vendor_error_i, stop_event_i} <= m;
		@(posedge clk_i);
	endtask : pulse
	task automatic clear_faults;
		fault_reset_i <= 1'b1;
		repeat (4) @(posedge clk_i);
		fault_reset_i <= 1'b0;
		@(posedge clk_i);
	endtask : clear_faults
	// Failure request and its expected abort, back to back with the next call
	task automatic sdo(input int c, input logic w);
		fer_sdo_fail_t f;
		logic [31:0] code;
		f = {fer_fail_t'(c), w, 16'($random(seed)), 8'($random(seed)), 16'($random(seed))};
		code = codes[c];
		if (code == AB_RANGE_LARGE && !w) code = AB_GENERAL;
		exp_q.push_back({code == AB_GENERAL, f.vendor_detail, code, f.subindex, f.index, ABORT_CMD});
		sdo_fail_valid_i <= 1'b1;
		sdo_fail_i <= f;
		@(posedge clk_i);
	endtask : sdo
	always @(posedge clk_i) begin
		if (rx_o === 1'b1) begin
			e = exp_q.pop_front();
			`CHK(rx_msg, e[63:0])
			if (e[80]) `CHK(rx_detail, e[79:64])
		end
	end
	initial begin
		#(20 * 3000);
		errors++;
		end_of_test();
	end
	initial begin
		// Codes in cause order
		codes = '{AB_TOGGLE, AB_TIMEOUT, AB_BAD_CS, AB_NO_MEMORY, AB_NO_ACCESS, AB_WRITE_ONLY,
			AB_READ_ONLY, AB_NO_OBJECT, AB_NOT_MAPPABLE, AB_MAP_TOO_LONG, AB_INCOMPATIBLE,
			AB_INTERNAL_INC, AB_HW_ERROR, AB_LEN_MISMATCH, AB_TOO_LONG, AB_TOO_SHORT,
			AB_NO_SUBINDEX, AB_RANGE_LARGE, AB_ABOVE_MAX, AB_BELOW_MIN, AB_UPPER_LOWER,
			AB_GENERAL, AB_NOT_STORED, AB_LOCAL_CTRL, AB_DEV_STATE, AB_NO_DICT, AB_NO_DATA};
		repeat (6) @(posedge clk_i);
		rstn_i <= 1'b1;
		@(posedge clk_i);
		for (int i = 0; i < 27; i++) sdo(i, 1'($random(seed)));
		sdo(17, 1'b0);
		sdo(17, 1'b1);
		sdo_fail_valid_i <= 1'b0;
		repeat (3) @(posedge clk_i);
		`CHK(bitcoded_error_register_o, 8'h91)
		clear_faults();
		`CHK(bitcoded_error_register_o, 8'h00)
		pulse(4'h8);
		pulse(4'h4);
		pulse(4'h2);
		sc = 16'($random(seed));
		stop_code_i <= sc;
		pulse(4'h1);
		pulse(4'h0);
		`CHK(emcy_valid_o, 1'b1)
		`CHK(emcy_o.error_code, sc)
		`CHK(emcy_o.error_register, 8'hb1)
		`CHK(last_stop_code_o, sc)
		`CHK(bitcoded_error_register_o, 8'hb1)
		acc = 32'h0;
		for (int i = 0; i < 4; i++) begin
			r = $random(seed);
			monitor_raw_i <= r;
			repeat (4) @(posedge clk_i);
			`CHK(latched_monitor_signals_o, (acc | r) & MON_USED_MASK)
			acc |= r;
		end
		monitor_raw_i <= 32'h0;
		repeat (4) @(posedge clk_i);
		`CHK(latched_monitor_signals_o, acc & MON_USED_MASK)
		clear_faults();
		`CHK(latched_monitor_signals_o, 32'h0)
		`CHK(last_stop_code_o, 16'h0)
		// An event seen while the clock enable is low must leave no trace
		ce_i <= 1'b0;
		stop_code_i <= ~sc;
		pulse(4'h1);
		pulse(4'h0);
		`CHK(last_stop_code_o, 16'h0)
		`CHK(emcy_valid_o, 1'b0)
		`CHK(bitcoded_error_register_o, 8'h00)
		ce_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		`CHK(exp_q.size(), 0)
		end_of_test();
	end
endmodule : test_fer_error_report
